// *** spi_master_pkg.sv ***
// shared constants, types and helpers of the buffered spi master
`default_nettype none

package spi_master_pkg;

   // system clock and serial rate table
   localparam int CLK_HZ = 40_000_000;
   localparam int BASE_RATE_BPS = 125_000;
   localparam int RATE_STEPS = 7;
   localparam logic [31:0] RATE_CODE_SLOWEST = 32'h0200_0000;

   // pin levels outside a transaction
   localparam logic CSN_IDLE = 1'b1;
   localparam logic DCX_IDLE = 1'b1;
   localparam logic MOSI_IDLE = 1'b0;

   // last bit index inside a byte
   localparam logic [2:0] BIT_LAST = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_NEXT   = 3'b001,
      ST_FETCH  = 3'b010,
      ST_SHIFT  = 3'b011,
      ST_PAUSE  = 3'b100,
      ST_FINISH = 3'b101
   } engine_state_t;

   typedef struct packed {
      logic cpol;
      logic cpha;
      logic lsb_first;
   } spi_config_t;

   // connect bits, one per signal
   typedef struct packed {
      logic sck;
      logic chip_select;
      logic command_select_pin;
      logic mosi;
      logic miso;
   } pin_select_t;

   typedef struct packed {
      logic sck;
      logic csn_n;
      logic dcx;
      logic mosi;
   } pin_drive_t;

   typedef struct packed {
      logic start;
      logic stop;
      logic suspend;
      logic resume;
   } task_t;

   typedef struct packed {
      logic started;
      logic tx_buffer_done_event;
      logic rx_buffer_done_event;
      logic all_done;
      logic stopped;
   } event_t;

   // system clocks per half serial bit; unknown codes run at the slowest rate
   function automatic logic [7:0] half_period(input logic [31:0] code);
      int base;
      int h;
      base = CLK_HZ / (2 * BASE_RATE_BPS);
      half_period = 8'(base);
      for (int k = 0; k < RATE_STEPS; k++) begin
         h = base >> k;
         if (code == (RATE_CODE_SLOWEST << k)) begin
            half_period = 8'((h > 1) ? h : 1);
         end
      end
   endfunction : half_period

endpackage : spi_master_pkg

`default_nettype wire

// *** bit_synchroniser.sv ***
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none

module bit_synchroniser (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // asynchronous level in, synchronised level out
   input wire logic async_in,
   output logic sync_out
);

   typedef struct packed {
      logic first;
      logic second;
   } sync_state_t;

   sync_state_t q;
   sync_state_t d;

   // the first stage feeds only the second
   always_comb begin
      d = q;
      d.first = async_in;
      d.second = q.first;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.second;

endmodule : bit_synchroniser

`default_nettype wire

// *** buffered_spi_master.sv ***
// buffered spi master engine: byte sequencing, shifter, events and pins
// Function
// - start task begins full-duplex transfer, shifting mosi out and miso in
// - tx done event once tx byte count bytes have been sent
// - rx done event once rx byte count bytes have been captured
// - transfer ends by itself, no clocking, when all bytes are handled
// - bytes beyond tx count send the over-read character
// - all-done event only after both tx and rx done events
// - stop lets the byte in progress finish in both directions
// - stopped event once fully halted after a stop
// - tx done fires at halt if it has not fired yet
// - rx done fires at halt if it has not fired yet
// - suspend pauses at byte end; resume continues the same transfer
// - command select low for command bytes, high for data bytes
// - command byte count sets leading command bytes; own pin connect
// - pin selections act only while enabled; lost at power-down
// - spi modes zero to three from cpol and cpha
// - bit order: 0 msb first, 1 lsb first
// - cpha 0 samples leading edge; cpha 1 samples trailing edge
// - received bytes beyond rx count are discarded
// - one-hot rate code picks 125 kbps up to 10 Mbps
`timescale 1ns/1ps
`default_nettype none

module buffered_spi_master #(
   parameter int CNT_W = 16,
   parameter int ADDR_W = 32
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // control and configuration
   input wire logic enable_in,
   input wire spi_master_pkg::task_t tasks_in,
   input wire spi_master_pkg::spi_config_t config_in,
   input wire logic [31:0] rate_code_in,
   input wire logic [7:0] over_read_character_in,
   input wire logic [CNT_W-1:0] command_byte_count_in,
   input wire spi_master_pkg::pin_select_t pin_select_in,
   // transmit buffer
   input wire logic [ADDR_W-1:0] tx_buffer_pointer_in,
   input wire logic [CNT_W-1:0] tx_byte_count_in,
   output logic tx_rd_req_out,
   output logic [ADDR_W-1:0] tx_rd_addr_out,
   input wire logic [7:0] tx_rd_data_in,
   input wire logic tx_rd_valid_in,
   // receive buffer
   input wire logic [ADDR_W-1:0] rx_buffer_pointer_in,
   input wire logic [CNT_W-1:0] rx_byte_count_in,
   output logic rx_wr_req_out,
   output logic [ADDR_W-1:0] rx_wr_addr_out,
   output logic [7:0] rx_wr_data_out,
   // events and status
   output spi_master_pkg::event_t events_out,
   output logic busy_out,
   // serial pins
   input wire logic miso_in,
   output spi_master_pkg::pin_drive_t pins_out,
   output spi_master_pkg::pin_drive_t pins_oe_out
);

   typedef struct packed {
      spi_master_pkg::engine_state_t st;
      spi_master_pkg::spi_config_t cfg;
      logic [7:0] half_lim;
      logic [7:0] cnt;
      logic half;
      logic [2:0] bit_idx;
      logic [7:0] sh;
      logic [7:0] rx;
      logic [7:0] over_read_character;
      logic [CNT_W-1:0] byte_n;
      logic [CNT_W-1:0] tx_cnt;
      logic [CNT_W-1:0] rx_cnt;
      logic [CNT_W-1:0] total;
      logic [CNT_W-1:0] cmd_cnt;
      logic [ADDR_W-1:0] tx_ptr;
      logic [ADDR_W-1:0] rx_ptr;
      logic tx_fired;
      logic rx_fired;
      logic end_fired;
      logic stop_pend;
      logic susp_pend;
      logic busy;
      logic tx_rd;
      logic [ADDR_W-1:0] tx_addr;
      logic rx_wr;
      logic [ADDR_W-1:0] rx_addr;
      logic [7:0] rx_data;
      spi_master_pkg::event_t ev;
      spi_master_pkg::pin_drive_t pins;
      spi_master_pkg::pin_drive_t oe;
   } state_t;

   state_t q;
   state_t d;
   logic miso_s;
   logic miso_bit;

   // miso is a pin: two flops before the shifter sees it; this adds two
   // system clocks of sampling delay, fine since a half bit is at least two
   bit_synchroniser miso_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .async_in(miso_in),
      .sync_out(miso_s)
   );

   // an unconnected miso reads as zero rather than a floating level
   assign miso_bit = miso_s & pin_select_in.miso & enable_in;

   // set up the shifter for one byte and present its first bit
   function automatic state_t begin_byte(input state_t s, input logic [7:0] b);
      state_t r;
      r = s;
      r.sh = b;
      r.rx = 8'h00;
      r.bit_idx = 3'h0;
      r.half = 1'b0;
      r.cnt = s.half_lim - 1'b1;
      r.pins.mosi = s.cfg.lsb_first ? b[0] : b[7];
      r.pins.sck = s.cfg.cpol ^ s.cfg.cpha;
      r.pins.dcx = (s.byte_n >= s.cmd_cnt);
      r.st = spi_master_pkg::ST_SHIFT;
      return r;
   endfunction : begin_byte

   always_comb begin
      d = q;
      d.ev = '0;
      d.tx_rd = 1'b0;
      d.rx_wr = 1'b0;
      // pin drivers only while enabled and connected
      d.oe.sck = enable_in & pin_select_in.sck;
      d.oe.csn_n = enable_in & pin_select_in.chip_select;
      d.oe.dcx = enable_in & pin_select_in.command_select_pin;
      d.oe.mosi = enable_in & pin_select_in.mosi;
      if (tasks_in.stop) begin
         d.stop_pend = 1'b1;
      end
      if (tasks_in.suspend) begin
         d.susp_pend = 1'b1;
      end else if (tasks_in.resume) begin
         d.susp_pend = 1'b0;
      end
      // all-done one cycle after the second of the two buffer events
      if (q.tx_fired && q.rx_fired && !q.end_fired) begin
         d.ev.all_done = 1'b1;
         d.end_fired = 1'b1;
      end
      case (q.st)
         spi_master_pkg::ST_IDLE: begin
            d.pins.sck = config_in.cpol;
            d.pins.csn_n = spi_master_pkg::CSN_IDLE;
            d.pins.dcx = spi_master_pkg::DCX_IDLE;
            d.pins.mosi = spi_master_pkg::MOSI_IDLE;
            d.stop_pend = 1'b0;
            d.susp_pend = 1'b0;
            if (tasks_in.stop) begin
               d.ev.stopped = 1'b1;
            end
            if (enable_in && tasks_in.start) begin
               // counts latched here, later changes do not disturb the run
               d.cfg = config_in;
               d.half_lim = spi_master_pkg::half_period(rate_code_in);
               d.over_read_character = over_read_character_in;
               d.tx_cnt = tx_byte_count_in;
               d.rx_cnt = rx_byte_count_in;
               d.total = (tx_byte_count_in > rx_byte_count_in) ?
                         tx_byte_count_in : rx_byte_count_in;
               d.cmd_cnt = command_byte_count_in;
               d.tx_ptr = tx_buffer_pointer_in;
               d.rx_ptr = rx_buffer_pointer_in;
               d.byte_n = '0;
               d.tx_fired = 1'b0;
               d.rx_fired = 1'b0;
               d.end_fired = 1'b0;
               d.pins.sck = config_in.cpol;
               d.pins.csn_n = 1'b0;
               d.ev.started = 1'b1;
               d.st = spi_master_pkg::ST_NEXT;
            end
         end
         spi_master_pkg::ST_NEXT: begin
            if (q.byte_n == q.total || q.stop_pend) begin
               d.st = spi_master_pkg::ST_FINISH;
            end else if (q.susp_pend) begin
               d.st = spi_master_pkg::ST_PAUSE;
            end else if (q.byte_n < q.tx_cnt) begin
               d.tx_rd = 1'b1;
               d.tx_addr = q.tx_ptr + ADDR_W'(q.byte_n);
               d.st = spi_master_pkg::ST_FETCH;
            end else begin
               d = begin_byte(d, q.over_read_character);
            end
         end
         spi_master_pkg::ST_FETCH: begin
            if (tx_rd_valid_in) begin
               d = begin_byte(d, tx_rd_data_in);
            end
         end
         spi_master_pkg::ST_PAUSE: begin
            // clock rests at idle; a stop also leaves the pause
            if (!q.susp_pend || q.stop_pend) begin
               d.st = spi_master_pkg::ST_NEXT;
            end
         end
         spi_master_pkg::ST_SHIFT: begin
            if (q.cnt != 8'h00) begin
               d.cnt = q.cnt - 1'b1;
            end else begin
               d.cnt = q.half_lim - 1'b1;
               if (!q.half) begin
                  // mid-bit edge: leading for cpha 0, trailing for cpha 1
                  d.half = 1'b1;
                  d.pins.sck = ~q.pins.sck;
                  d.rx = q.cfg.lsb_first ? {miso_bit, q.rx[7:1]} :
                                           {q.rx[6:0], miso_bit};
               end else if (q.bit_idx != spi_master_pkg::BIT_LAST) begin
                  d.half = 1'b0;
                  d.bit_idx = q.bit_idx + 1'b1;
                  d.sh = q.cfg.lsb_first ? {1'b0, q.sh[7:1]} :
                                           {q.sh[6:0], 1'b0};
                  d.pins.mosi = q.cfg.lsb_first ? d.sh[0] : d.sh[7];
                  d.pins.sck = q.cfg.cpol ^ q.cfg.cpha;
               end else begin
                  // byte boundary: stop and suspend are acted on only in the next state, between bytes
                  d.pins.sck = q.cfg.cpol;
                  if (q.byte_n < q.rx_cnt) begin
                     d.rx_wr = 1'b1;
                     d.rx_addr = q.rx_ptr + ADDR_W'(q.byte_n);
                     d.rx_data = q.rx;
                  end
                  if (q.byte_n + 1'b1 == q.tx_cnt) begin
                     d.ev.tx_buffer_done_event = 1'b1;
                     d.tx_fired = 1'b1;
                  end
                  if (q.byte_n + 1'b1 == q.rx_cnt) begin
                     d.ev.rx_buffer_done_event = 1'b1;
                     d.rx_fired = 1'b1;
                  end
                  d.byte_n = q.byte_n + 1'b1;
                  d.st = spi_master_pkg::ST_NEXT;
               end
            end
         end
         spi_master_pkg::ST_FINISH: begin
            if (!q.tx_fired) begin
               d.ev.tx_buffer_done_event = 1'b1;
               d.tx_fired = 1'b1;
            end
            if (!q.rx_fired) begin
               d.ev.rx_buffer_done_event = 1'b1;
               d.rx_fired = 1'b1;
            end
            if (q.stop_pend) begin
               d.ev.stopped = 1'b1;
            end
            d.stop_pend = 1'b0;
            d.susp_pend = 1'b0;
            d.pins.csn_n = spi_master_pkg::CSN_IDLE;
            d.pins.dcx = spi_master_pkg::DCX_IDLE;
            d.pins.mosi = spi_master_pkg::MOSI_IDLE;
            d.st = spi_master_pkg::ST_IDLE;
         end
         default: begin
            d.st = spi_master_pkg::ST_IDLE;
         end
      endcase
      // disabling aborts silently; no events are owed after that
      if (!enable_in && q.st != spi_master_pkg::ST_IDLE) begin
         d.st = spi_master_pkg::ST_IDLE;
         d.pins.csn_n = spi_master_pkg::CSN_IDLE;
      end
      d.busy = (d.st != spi_master_pkg::ST_IDLE);
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         q <= '0;
         q.pins.csn_n <= spi_master_pkg::CSN_IDLE;
         q.pins.dcx <= spi_master_pkg::DCX_IDLE;
      end else begin
         q <= d;
      end
   end

   assign tx_rd_req_out = q.tx_rd;
   assign tx_rd_addr_out = q.tx_addr;
   assign rx_wr_req_out = q.rx_wr;
   assign rx_wr_addr_out = q.rx_addr;
   assign rx_wr_data_out = q.rx_data;
   assign events_out = q.ev;
   assign busy_out = q.busy;
   assign pins_out = q.pins;
   assign pins_oe_out = q.oe;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_clock_quiet;
      (q.pins.sck == q.cfg.cpol)[*3];
   endsequence

   sequence s_started;
      q.st == spi_master_pkg::ST_IDLE && enable_in && tasks_in.start;
   endsequence

   chk_start_selects: assert property (
      s_started |=> q.pins.csn_n == 1'b0 && events_out.started)
      else $error("start did not select the slave");
   chk_finish_quiet: assert property (
      q.st == spi_master_pkg::ST_FINISH |=> s_clock_quiet)
      else $error("serial clock moved after the transfer ended");
   chk_all_done_after: assert property (
      events_out.all_done |-> $past(q.tx_fired) && $past(q.rx_fired))
      else $error("all-done before both buffer events");
   chk_halt_fires: assert property (
      q.st == spi_master_pkg::ST_FINISH && enable_in
      |=> q.tx_fired && q.rx_fired)
      else $error("buffer events not owed out at halt");
   chk_stop_event: assert property (
      events_out.stopped && $past(q.st) != spi_master_pkg::ST_IDLE
      |-> $past(q.stop_pend) && q.st == spi_master_pkg::ST_IDLE)
      else $error("stopped event without a stop");
   chk_stop_byte_whole: assert property (
      q.st == spi_master_pkg::ST_SHIFT && q.stop_pend && enable_in
      |=> q.st == spi_master_pkg::ST_SHIFT || q.st == spi_master_pkg::ST_NEXT)
      else $error("stop cut a byte short");
   chk_pause_holds: assert property (
      q.st == spi_master_pkg::ST_PAUSE && q.susp_pend && !q.stop_pend
      && !tasks_in.resume && !tasks_in.stop && enable_in
      |=> q.st == spi_master_pkg::ST_PAUSE && q.pins.sck == q.cfg.cpol)
      else $error("suspended transfer moved");
   chk_dcx_level: assert property (
      q.st == spi_master_pkg::ST_SHIFT
      |-> q.pins.dcx == (q.byte_n >= q.cmd_cnt))
      else $error("command select level wrong");
   chk_orc_loaded: assert property (
      q.st == spi_master_pkg::ST_NEXT && q.byte_n >= q.tx_cnt
      && q.byte_n < q.total && !q.stop_pend && !q.susp_pend && enable_in
      |=> q.sh == q.over_read_character && q.st == spi_master_pkg::ST_SHIFT)
      else $error("over-read character not sent");
   chk_rx_discard: assert property (
      rx_wr_req_out |-> $past(q.byte_n) < q.rx_cnt)
      else $error("byte written past the receive count");

endmodule : buffered_spi_master

`default_nettype wire

// *** spi_slave.sv ***
// behavioural spi slave that records mosi and dcx and answers on miso
`timescale 1ns/1ps
`default_nettype none

module spi_slave (
   // serial pins from the master
   input wire logic sck_in,
   input wire logic csn_n_in,
   input wire logic mosi_in,
   input wire logic dcx_in,
   // mode the master runs in
   input wire spi_master_pkg::spi_config_t config_in,
   // answer line
   output logic miso_out
);
   logic [7:0] out_q[$];
   logic [7:0] mosi_q[$];
   logic dcx_q[$];
   realtime lead_t[$];
   logic [7:0] sh_in;
   logic [7:0] sh_out;
   int nbits;
   int k;

   initial begin
      miso_out = 1'b0;
      nbits = 0;
      k = 0;
   end

   // a new byte is loaded when no bit of the current one is outstanding
   task put();
      if (nbits == 0) begin
         sh_out = (k < out_q.size()) ? out_q[k] : 8'h3C;
         k++;
      end
      miso_out <= #2 config_in.lsb_first ? sh_out[0] : sh_out[7];
      sh_out = config_in.lsb_first ? sh_out >> 1 : sh_out << 1;
   endtask : put

   always @(negedge csn_n_in) begin
      nbits = 0;
      k = 0;
      lead_t.delete();
      if (!config_in.cpha) begin
         put();
      end
   end

   // released line must not keep the last bit
   always @(posedge csn_n_in) miso_out <= #2 ~miso_out;

   always @(sck_in) begin
      if (csn_n_in === 1'b0) begin
         if (sck_in !== config_in.cpol) begin
            lead_t.push_back($realtime);
         end
         if ((sck_in !== config_in.cpol) == !config_in.cpha) begin
            sh_in = config_in.lsb_first ? {mosi_in, sh_in[7:1]}
                                        : {sh_in[6:0], mosi_in};
            nbits++;
            if (nbits == 8) begin
               mosi_q.push_back(sh_in);
               dcx_q.push_back(dcx_in);
               nbits = 0;
            end
         end else begin
            put();
         end
      end
   end
endmodule : spi_slave

`default_nettype wire

// *** spi_master_buffered_transfer_test.sv ***
// self-checking bench for the buffered spi master
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin \
   miscompares++; $display("FAIL %0t %s", $time, m); end end

module spi_master_buffered_transfer_test;
   logic clk_in, rst_n_in, enable_in;
   spi_master_pkg::task_t tasks;
   spi_master_pkg::spi_config_t cfg;
   spi_master_pkg::pin_select_t psel;
   spi_master_pkg::event_t ev;
   spi_master_pkg::pin_drive_t pins, pins_oe;
   logic [31:0] rate, txp, rxp, tx_addr, rx_addr;
   logic [15:0] ncmd, ntx, nrx;
   logic [7:0] over_read_character, tx_data, rx_data;
   logic tx_req, tx_vld, rx_req, busy, miso;
   int miscompares, cmp_count, seed, lat, cyc;
   int n_ev[5];
   int t_ev[5];
   logic [7:0] txm[$];
   logic [31:0] rx_a[$];
   logic [7:0] rx_d[$];

   buffered_spi_master u_buffered_spi_master (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .enable_in(enable_in),
      .tasks_in(tasks), .config_in(cfg), .rate_code_in(rate),
      .over_read_character_in(over_read_character), .command_byte_count_in(ncmd),
      .pin_select_in(psel), .tx_buffer_pointer_in(txp),
      .tx_byte_count_in(ntx), .tx_rd_req_out(tx_req),
      .tx_rd_addr_out(tx_addr), .tx_rd_data_in(tx_data),
      .tx_rd_valid_in(tx_vld), .rx_buffer_pointer_in(rxp),
      .rx_byte_count_in(nrx), .rx_wr_req_out(rx_req),
      .rx_wr_addr_out(rx_addr), .rx_wr_data_out(rx_data),
      .events_out(ev), .busy_out(busy), .miso_in(miso),
      .pins_out(pins), .pins_oe_out(pins_oe));

   // chip select comes from the engine here, no extra pin drive
   spi_slave u_spi_slave (.sck_in(pins.sck), .csn_n_in(pins.csn_n),
      .mosi_in(pins.mosi), .dcx_in(pins.dcx), .config_in(cfg),
      .miso_out(miso));

   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   // event log, receive memory and transmit memory with random latency
   always @(posedge clk_in) begin
      cyc++;
      for (int i = 0; i < 5; i++) begin
         if (ev[i] === 1'b1) begin
            n_ev[i]++;
            t_ev[i] = cyc;
         end
      end
      if (rx_req === 1'b1) begin
         rx_a.push_back(rx_addr);
         rx_d.push_back(rx_data);
      end
      tx_vld <= 1'b0;
      if (tx_req === 1'b1) begin
         lat = 1 + {$random(seed)} % 3;
      end else if (lat > 0) begin
         lat--;
         if (lat == 0) begin
            tx_vld <= 1'b1;
            tx_data <= txm[tx_addr - txp];
         end
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask : tick

   task automatic pulse(input spi_master_pkg::task_t t);
      @(posedge clk_in);
      tasks <= t;
      @(posedge clk_in);
      tasks <= '0;
   endtask : pulse

   task automatic close_out();
      $display("checks %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   // op: 0 plain, 1 stop in byte 0, 2 suspend in byte 0 then resume
   task automatic run(input int nt, nr, nc, md, lsb, ri, op);
      int nb, h, n;
      nb = (op == 1) ? 1 : ((nt > nr) ? nt : nr);
      h = 160 >> ri;
      @(posedge clk_in);
      cfg <= {md[1], md[0], lsb[0]};
      rate <= 32'h0200_0000 << ri;
      ncmd <= 16'(nc);
      ntx <= 16'(nt);
      nrx <= 16'(nr);
      over_read_character <= 8'($random(seed));
      txp <= $random(seed);
      rxp <= $random(seed);
      txm.delete();
      rx_a.delete();
      rx_d.delete();
      u_spi_slave.out_q.delete();
      u_spi_slave.mosi_q.delete();
      u_spi_slave.dcx_q.delete();
      for (int i = 0; i < 6; i++) begin
         txm.push_back(8'($random(seed)));
         u_spi_slave.out_q.push_back(8'($random(seed)));
      end
      n_ev = '{default: 0};
      t_ev = '{default: 0};
      pulse(4'h8);
      if (op != 0) begin
         tick(6);
         pulse((op == 1) ? 4'h4 : 4'h2);
         if (op == 2) begin
            tick(300);
            `CHK(u_spi_slave.mosi_q.size(), 1, "suspend bytes")
            `CHK(pins.sck, cfg.cpol, "suspend sck")
            `CHK(busy, 1'b1, "suspend busy")
            pulse(4'h1);
         end
      end
      tick(2);
      n = 0;
      while (busy !== 1'b0 && n < 20000) begin
         @(posedge clk_in);
         n++;
      end
      `CHK(busy, 1'b0, "end of transfer")
      tick(4);
      `CHK(u_spi_slave.mosi_q.size(), nb, "byte count")
      for (int k = 0; k < nb; k++) begin
         `CHK(u_spi_slave.mosi_q[k], (k < nt) ? txm[k] : over_read_character, "mosi")
         `CHK(u_spi_slave.dcx_q[k], 1'(k >= nc), "dcx")
      end
      `CHK(rx_a.size(), (nb < nr) ? nb : nr, "rx writes")
      for (int k = 0; k < rx_a.size(); k++) begin
         `CHK(rx_a[k], rxp + 32'(k), "rx addr")
         `CHK(rx_d[k], u_spi_slave.out_q[k], "rx data")
      end
      if (u_spi_slave.lead_t.size() > 1) begin
         n = int'(u_spi_slave.lead_t[1] - u_spi_slave.lead_t[0]);
         `CHK(n, 50 * h, "bit period")
      end
      `CHK(n_ev[4], 1, "started")
      `CHK(n_ev[3], 1, "tx done")
      `CHK(n_ev[2], 1, "rx done")
      `CHK(n_ev[1], 1, "all done")
      `CHK(n_ev[0], (op == 1) ? 1 : 0, "stopped")
      `CHK(t_ev[1] > t_ev[2] && t_ev[1] > t_ev[3], 1'b1, "order")
      `CHK(pins.sck, cfg.cpol, "idle sck")
      `CHK(pins.csn_n, 1'b1, "idle select")
      $display("test done tx %0d rx %0d mode %0d op %0d", nt, nr, md, op);
   endtask : run

   initial begin
      #1000000;
      miscompares++;
      $display("FAIL %0t watchdog", $time);
      close_out();
   end

   initial begin
      seed = 40422;
      rst_n_in = 1'b0;
      enable_in = 1'b1;
      tasks = '0;
      cfg = '0;
      psel = '1;
      rate = 32'h0200_0000;
      {ncmd, ntx, nrx} = '0;
      {over_read_character, tx_data, txp, rxp} = '0;
      tx_vld = 1'b0;
      lat = 0;
      cyc = 0;
      miscompares = 0;
      cmp_count = 0;
      tick(6);
      rst_n_in <= 1'b1;
      run(3, 5, 1, 0, 0, 4, 0);
      run(4, 2, 2, 1, 1, 5, 0);
      run(2, 2, 0, 2, 1, 3, 0);
      run(2, 3, 4, 3, 0, 5, 0);
      run(3, 0, 1, 0, 1, 6, 0);
      run(0, 0, 0, 0, 0, 4, 0);
      run(1, 1, 0, 1, 0, 0, 0);
      run(3, 3, 1, 2, 0, 4, 1);
      run(2, 4, 1, 3, 1, 4, 2);
      for (int i = 0; i < 3; i++) begin
         run({$random(seed)} % 5, {$random(seed)} % 5, {$random(seed)} % 3,
             {$random(seed)} % 4, {$random(seed)} % 2,
             3 + {$random(seed)} % 3, 0);
      end
      pulse(4'h4);
      tick(2);
      `CHK(n_ev[0], 1, "stop while idle")
      @(posedge clk_in);
      enable_in <= 1'b0;
      tick(2);
      psel <= 5'($random(seed));
      tick(3);
      `CHK(pins_oe, 4'h0, "oe while disabled")
      enable_in <= 1'b1;
      tick(3);
      `CHK(pins_oe, {psel.sck, psel.chip_select, psel.command_select_pin, psel.mosi}, "oe")
      close_out();
   end
endmodule : spi_master_buffered_transfer_test

`default_nettype wire
